/* verilog/ccp_defines.vh */
// constants for the counter array capture/compare/pwm module
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH
// ==========================================
// mode register field positions
`define CCP_MODE_FORCE_LEVEL  7
`define CCP_MODE_CMP_EN       6
`define CCP_MODE_RISE_CAP     5
`define CCP_MODE_FALL_CAP     4
`define CCP_MODE_MATCH_FLAG   3
`define CCP_MODE_TOGGLE       2
`define CCP_MODE_PWM          1
`define CCP_MODE_IRQ_EN       0
// ==========================================
// reset values
`define CCP_MODE_RESET        8'h00
`define CCP_VALUE_RESET       8'h00
`define CCP_PIN_RESET         1'h0
// ==========================================
// active mode codes
`define CCP_ST_NOP            3'h0
`define CCP_ST_CAPTURE        3'h1
`define CCP_ST_COMPARE        3'h2
`define CCP_ST_PWM8           3'h3
`define CCP_ST_PWM16          3'h4
`define CCP_ST_WINDOWED_PWM           3'h5
`endif

/* verilog/ccp_module.v */
// one capture/compare/pwm module of the counter array
`timescale 1ns/1ps
`include "ccp_defines.vh"

module ccp_module (
   input  wire        clk,
   input  wire        resetn,
   input  wire [7:0]  count_high,
   input  wire [7:0]  count_low,
   input  wire        count_step,
   input  wire        count_overflow,
   input  wire        mode_wr,
   input  wire [7:0]  mode_wdata,
   input  wire        value_low_wr,
   input  wire        value_high_wr,
   input  wire [7:0]  value_wdata,
   input  wire        flag_clear,
   input  wire        module_io_pin_in,
   output reg  [7:0]  module_mode_reg,
   output reg  [7:0]  module_value_high,
   output reg  [7:0]  module_value_low,
   output reg         module_event_flag,
   output wire        module_irq,
   output reg         module_io_pin_out,
   output wire        module_io_pin_oe_n,
   output reg  [2:0]  active_mode
);

   // ==========================================
   // mode decode
   wire        force_level_sel   = module_mode_reg[`CCP_MODE_FORCE_LEVEL];
   wire        comparator_enable = module_mode_reg[`CCP_MODE_CMP_EN];
   wire        rise_capture_en   = module_mode_reg[`CCP_MODE_RISE_CAP];
   wire        fall_capture_en   = module_mode_reg[`CCP_MODE_FALL_CAP];
   wire        match_flag_enable = module_mode_reg[`CCP_MODE_MATCH_FLAG];
   wire        toggle_sel        = module_mode_reg[`CCP_MODE_TOGGLE];
   wire        pwm_sel           = module_mode_reg[`CCP_MODE_PWM];
   wire        module_irq_enable = module_mode_reg[`CCP_MODE_IRQ_EN];

   always @* begin
      if (comparator_enable && pwm_sel && rise_capture_en && fall_capture_en)
         active_mode = `CCP_ST_WINDOWED_PWM;
      else if (comparator_enable && pwm_sel && rise_capture_en)
         active_mode = `CCP_ST_PWM16;
      else if (comparator_enable && pwm_sel && !rise_capture_en && !fall_capture_en)
         active_mode = `CCP_ST_PWM8;
      else if (rise_capture_en || fall_capture_en)
         active_mode = `CCP_ST_CAPTURE;
      else if (comparator_enable)
         active_mode = `CCP_ST_COMPARE;
      else
         active_mode = `CCP_ST_NOP;
   end

   // ==========================================
   // pin synchroniser and edge detect
   wire        rise_edge;
   wire        fall_edge;

   ccp_pin_edge u_pin_edge (
      .clk    (clk),
      .resetn (resetn),
      .din    (module_io_pin_in),
      .rise   (rise_edge),
      .fall   (fall_edge)
   );

   // a capture takes the count standing at the edge
   wire capture_hit = (active_mode == `CCP_ST_CAPTURE) &&
                      ((rise_capture_en && rise_edge) || (fall_capture_en && fall_edge));

   // ==========================================
   // comparators against the active (buffered) values
   reg  [7:0]  act_high;
   reg  [7:0]  act_low;
   wire [15:0] count16 = {count_high, count_low};
   wire [15:0] act16   = {act_high, act_low};
   wire        eq16;
   wire        gt16;
   wire        eq_low;
   wire        gt_low;
   wire        eq_high;
   wire        gt_high;
   // ff with a step is the low byte roll-over
   wire        low_wrap = count_step && (count_low == 8'hff);

   ccp_cmp #(.WIDTH(16)) u_cmp16 (
      .step  (count_step),
      .count (count16),
      .limit (act16),
      .eq    (eq16),
      .gt    (gt16)
   );

   ccp_cmp #(.WIDTH(8)) u_cmp_low (
      .step  (count_step),
      .count (count_low),
      .limit (act_low),
      .eq    (eq_low),
      .gt    (gt_low)
   );

   ccp_cmp #(.WIDTH(8)) u_cmp_high (
      .step  (count_step),
      .count (count_low),
      .limit (act_high),
      .eq    (eq_high),
      .gt    (gt_high)
   );

   // ==========================================
   // buffered value load
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         act_high <= `CCP_VALUE_RESET;
         act_low  <= `CCP_VALUE_RESET;
      end else begin
         case (active_mode)
            `CCP_ST_COMPARE, `CCP_ST_PWM16: begin
               if (count_overflow) begin
                  act_high <= module_value_high;
                  act_low  <= module_value_low;
               end
            end
            `CCP_ST_PWM8, `CCP_ST_WINDOWED_PWM: begin
               if (low_wrap) begin
                  act_high <= module_value_high;
                  act_low  <= module_value_low;
               end
            end
            default: begin
               // idle modes track software so a mode change starts clean
               act_high <= module_value_high;
               act_low  <= module_value_low;
            end
         endcase
      end
   end

   // ==========================================
   // mode register
   wire        mode_all_zero = (module_mode_reg == 8'h00);
   reg  [7:0]  next_mode;
   always @* begin
      next_mode = module_mode_reg;
      // a software mode write beats the hardware enable change
      if (mode_wr)
         next_mode = mode_wdata;
      else if (value_low_wr && comparator_enable)
         next_mode[`CCP_MODE_CMP_EN] = 1'h0;
      else if (value_high_wr && !mode_all_zero)
         next_mode[`CCP_MODE_CMP_EN] = 1'h1;
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         module_mode_reg <= `CCP_MODE_RESET;
      else
         module_mode_reg <= next_mode;
   end

   // ==========================================
   // value registers, a capture wins over a software write
   reg  [7:0]  next_value_high;
   reg  [7:0]  next_value_low;
   always @* begin
      next_value_high = module_value_high;
      next_value_low  = module_value_low;
      if (capture_hit) begin
         next_value_high = count_high;
         next_value_low  = count_low;
      end else begin
         if (value_high_wr)
            next_value_high = value_wdata;
         if (value_low_wr)
            next_value_low = value_wdata;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         module_value_high <= `CCP_VALUE_RESET;
         module_value_low  <= `CCP_VALUE_RESET;
      end else begin
         module_value_high <= next_value_high;
         module_value_low  <= next_value_low;
      end
   end

   // ==========================================
   // event detection
   wire cmp_event   = eq16 && match_flag_enable && module_irq_enable;
   wire pwm8_event  = eq_low && module_irq_enable;
   wire pwm16_event = eq16 && module_irq_enable;
   // high bound reports only with the match enable
   wire windowed_pwm_event  = module_irq_enable &&
                      (eq_low || (match_flag_enable && eq_high));

   reg event_hit;
   always @* begin
      case (active_mode)
         `CCP_ST_CAPTURE: event_hit = capture_hit;
         `CCP_ST_COMPARE: event_hit = cmp_event;
         `CCP_ST_PWM8:    event_hit = pwm8_event;
         `CCP_ST_PWM16:   event_hit = pwm16_event;
         `CCP_ST_WINDOWED_PWM:    event_hit = windowed_pwm_event;
         default:         event_hit = 1'h0;
      endcase
   end

   // ==========================================
   // event flag and interrupt
   // set wins over a clear in the same cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         module_event_flag <= 1'h0;
      else if (event_hit)
         module_event_flag <= 1'h1;
      else if (flag_clear)
         module_event_flag <= 1'h0;
   end
   assign module_irq = module_event_flag && module_irq_enable;

   // ==========================================
   // pin action at a compare match, free of the match flag enable
   reg match_pin;
   always @* begin
      case ({force_level_sel, toggle_sel})
         2'h1:    match_pin = !module_io_pin_out;
         2'h2:    match_pin = 1'h0;
         2'h3:    match_pin = 1'h1;
         default: match_pin = module_io_pin_out;
      endcase
   end

   // ==========================================
   // pin output
   reg next_pin;
   reg in_window;
   always @* begin
      next_pin  = module_io_pin_out;
      in_window = gt_low && !gt_high;
      case (active_mode)
         `CCP_ST_COMPARE: next_pin = eq16 ? match_pin : module_io_pin_out;
         `CCP_ST_PWM8:    next_pin = toggle_sel || gt_low;
         `CCP_ST_PWM16:   next_pin = toggle_sel || gt16;
         `CCP_ST_WINDOWED_PWM:    next_pin = toggle_sel ^ in_window;
         default:         next_pin = module_io_pin_out;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         module_io_pin_out <= `CCP_PIN_RESET;
      else
         module_io_pin_out <= next_pin;
   end

   // ==========================================
   // pin direction
   // capture samples the pin, no-op releases it, every other active mode drives it
   assign module_io_pin_oe_n = (active_mode == `CCP_ST_CAPTURE) ||
                               (active_mode == `CCP_ST_NOP);

endmodule

// ==========================================
// byte or word comparator, one per compared pair
module ccp_cmp #(
   parameter WIDTH = 8
) (
   input  wire             step,
   input  wire [WIDTH-1:0] count,
   input  wire [WIDTH-1:0] limit,
   output wire             eq,
   output wire             gt
);

   // equality only with the step so a held count matches once
   assign eq = step && (count == limit);
   // ordering is level based, the pwm outputs follow the count
   assign gt = (count > limit);

endmodule

// ==========================================
// pin synchroniser with edge detect on the second stage
module ccp_pin_edge (
   input  wire clk,
   input  wire resetn,
   input  wire din,
   output wire rise,
   output wire fall
);

   // first stage read only by the second stage
   reg meta;
   reg sync;
   reg prev;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta <= 1'h0;
         sync <= 1'h0;
         prev <= 1'h0;
      end else begin
         meta <= din;
         sync <= meta;
         prev <= sync;
      end
   end

   // idle low after reset, so a low pin gives no false edge
   assign rise = sync && !prev;
   assign fall = !sync && prev;

endmodule

/* testbench/ccp_pin_model.sv */
// outside source and load on the module pin
`timescale 1ns/1ps
// ==========
// pin model
module ccp_pin_model (
   input  wire pin_out,
   input  wire pin_oe_n,
   input  wire ext_level,
   output wire pin_in
);
   // module wins the wire while oe_n is low
   assign pin_in = pin_oe_n ? ext_level : pin_out;
endmodule

/* testbench/ccp_module_assertions.sv */
// port checker for the capture/compare/pwm module
`timescale 1ns/1ps
`include "ccp_defines.vh"
// ==========
// checker
module ccp_module_assertions (
   input wire       clk,
   input wire       resetn,
   input wire       count_step,
   input wire       mode_wr,
   input wire       value_low_wr,
   input wire       value_high_wr,
   input wire       flag_clear,
   input wire [7:0] module_mode_reg,
   input wire       module_event_flag,
   input wire       module_irq,
   input wire       module_io_pin_out,
   input wire [2:0] active_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire [2:0] cfg = module_mode_reg[6:4];
   property p_irq; module_irq == (module_event_flag & module_mode_reg[0]); endproperty
   a_irq: assert property (p_irq) else $error("irq not flag and enable");
   property p_hold; module_event_flag && !flag_clear |=> module_event_flag; endproperty
   a_hold: assert property (p_hold) else $error("event flag lost");
   property p_lowclr; value_low_wr && !mode_wr && active_mode == `CCP_ST_COMPARE
      |=> !module_mode_reg[6]; endproperty
   a_lowclr: assert property (p_lowclr) else $error("low write kept enable");
   property p_nop; value_high_wr && !mode_wr && module_mode_reg == 8'h00
      |=> module_mode_reg == 8'h00; endproperty
   a_nop: assert property (p_nop) else $error("high write left no-op");
   property p_cmp; cfg == 3'h4 && !module_mode_reg[1] |-> active_mode == `CCP_ST_COMPARE; endproperty
   a_cmp: assert property (p_cmp) else $error("compare not decoded");
   property p_off; cfg == 3'h0 && !module_mode_reg[1] |-> active_mode == `CCP_ST_NOP; endproperty
   a_off: assert property (p_off) else $error("no-op not decoded");
   property p_pwm8; cfg == 3'h4 && module_mode_reg[1] |-> active_mode == `CCP_ST_PWM8; endproperty
   a_pwm8: assert property (p_pwm8) else $error("pwm8 not decoded");
   property p_pwm16; cfg == 3'h6 && module_mode_reg[1] |-> active_mode == `CCP_ST_PWM16; endproperty
   a_pwm16: assert property (p_pwm16) else $error("pwm16 not decoded");
   property p_full; active_mode == `CCP_ST_PWM8 && module_mode_reg[2] && count_step && !mode_wr
      |=> module_io_pin_out; endproperty
   a_full: assert property (p_full) else $error("pwm8 toggle not high");
   c_cap: cover property (active_mode == `CCP_ST_CAPTURE && module_event_flag);
   c_windowed_pwm: cover property (active_mode == `CCP_ST_WINDOWED_PWM && module_io_pin_out);
   c_pwm16: cover property (active_mode == `CCP_ST_PWM16 && module_irq);
endmodule
bind ccp_module ccp_module_assertions chk (.*);

/* testbench/counter_array_ccp_modes_tb_top.sv */
// self-checking bench for the capture/compare/pwm module
`timescale 1ns/1ps
`include "ccp_defines.vh"
// ==========
// bench
module counter_array_ccp_modes_tb_top;
   reg        clk, resetn, count_step, count_overflow, mode_wr, flag_clear, ext;
   reg        value_low_wr, value_high_wr;
   reg  [7:0] count_high, count_low, mode_wdata, value_wdata;
   wire [7:0] module_mode_reg, module_value_high, module_value_low;
   wire [2:0] active_mode;
   wire       module_event_flag, module_irq, module_io_pin_out, module_io_pin_oe_n;
   wire       module_io_pin_in;
   integer    n_mismatch = 0, comparisons = 0, i;
   ccp_module dut (.*);
   ccp_pin_model pin (.pin_out(module_io_pin_out), .pin_oe_n(module_io_pin_oe_n),
      .ext_level(ext), .pin_in(module_io_pin_in));
   task chk(input [8*12-1:0] name, input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
         if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // sel 0 mode, 1 low value, 2 high value, 3 flag clear
   task wr(input [1:0] sel, input [7:0] d);
      begin
         @(posedge clk);
         {mode_wr, value_low_wr, value_high_wr, flag_clear} <= 4'h8 >> sel;
         mode_wdata <= d;
         value_wdata <= d;
         @(posedge clk);
         {mode_wr, value_low_wr, value_high_wr, flag_clear} <= 4'h0;
         #1;
      end
   endtask
   task step(input [7:0] h, input [7:0] l);
      begin
         @(posedge clk);
         {count_high, count_low} <= {h, l};
         count_overflow <= ({h, l} == 16'h0000);
         count_step <= 1'b1;
         @(posedge clk);
         {count_step, count_overflow} <= 2'h0;
         #1;
      end
   endtask
   task t_capture;
      begin
         wr(0, 8'h21);
         @(posedge clk);
         // count held still so the edge sees a known value
         {count_high, count_low} <= 16'h1234;
         count_step <= 1'b1;
         ext <= 1'b1;
         repeat (6) @(posedge clk);
         count_step <= 1'b0;
         #1;
         chk("cap_h", module_value_high, 8'h12);
         chk("cap_l", module_value_low, 8'h34);
         chk("cap_irq", module_irq, 8'h01);
         chk("cap_oe", module_io_pin_oe_n, 8'h01);
         wr(3, 8'h00);
         chk("clr", module_event_flag, 8'h00);
      end
   endtask
   task t_compare;
      begin
         wr(0, 8'h44);
         wr(1, 8'h10);
         chk("en_clr", module_mode_reg[6], 8'h00);
         wr(2, 8'h20);
         chk("en_set", module_mode_reg[6], 8'h01);
         step(8'h00, 8'h00);
         for (i = 0; i < 5; i = i + 1) begin
            wr(0, 40'h44_40_c0_c4_4d >> (32 - 8 * i));
            step(8'h20, 8'h10);
            chk("cmp_pin", module_io_pin_out, (5'b11010 >> (4 - i)) & 1);
            chk("cmp_flag", module_event_flag, i == 4);
         end
         wr(3, 8'h00);
      end
   endtask
   // values loaded in no-op so they reach the active copy
   task t_pwm(input [7:0] lo, input [7:0] hi, input [7:0] m, input [7:0] h, input [7:0] l,
      input [7:0] exp);
      begin
         wr(3, 8'h00);
         wr(0, 8'h00);
         wr(1, lo);
         wr(2, hi);
         chk("nop_en", module_mode_reg, 8'h00);
         wr(0, m);
         step(h, l);
         chk("pwm_pin", module_io_pin_out, exp);
         chk("pin_oe", module_io_pin_oe_n, 8'h00);
      end
   endtask
   // high bound written mid-period waits for the low byte roll-over
   task t_wbuf;
      begin
         t_pwm(8'h20, 8'h40, 8'h72, 8'h00, 8'h30, 8'h01);
         wr(2, 8'h28);
         step(8'h00, 8'h30);
         chk("wbuf_old", module_io_pin_out, 8'h01);
         step(8'h00, 8'hff);
         step(8'h00, 8'h30);
         chk("wbuf_new", module_io_pin_out, 8'h00);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      end_of_test;
   end
   initial begin
      resetn = 1'b0;
      {count_step, count_overflow, mode_wr, value_low_wr, value_high_wr, flag_clear, ext} = 7'h0;
      {count_high, count_low, mode_wdata, value_wdata} = 32'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk("rst_mode", module_mode_reg, `CCP_MODE_RESET);
      t_capture;
      t_compare;
      t_pwm(8'h80, 8'h00, 8'h43, 8'h00, 8'h80, 8'h00);
      chk("pwm8_flag", module_event_flag, 8'h01);
      t_pwm(8'h80, 8'h00, 8'h43, 8'h00, 8'h81, 8'h01);
      t_pwm(8'h80, 8'h00, 8'h47, 8'h00, 8'h10, 8'h01);
      t_pwm(8'h00, 8'h30, 8'h63, 8'h30, 8'h00, 8'h00);
      chk("pwm16_irq", module_irq, 8'h01);
      t_pwm(8'h00, 8'h30, 8'h63, 8'h30, 8'h01, 8'h01);
      t_pwm(8'h20, 8'h40, 8'h72, 8'h00, 8'h30, 8'h01);
      t_pwm(8'h20, 8'h40, 8'h72, 8'h00, 8'h50, 8'h00);
      t_pwm(8'h20, 8'h40, 8'h76, 8'h00, 8'h30, 8'h00);
      t_pwm(8'h20, 8'h40, 8'h73, 8'h00, 8'h40, 8'h01);
      chk("windowed_pwm_hi_off", module_event_flag, 8'h00);
      t_pwm(8'h20, 8'h40, 8'h7b, 8'h00, 8'h40, 8'h01);
      chk("windowed_pwm_hi", module_event_flag, 8'h01);
      t_pwm(8'h20, 8'h40, 8'h73, 8'h00, 8'h20, 8'h00);
      chk("windowed_pwm_lo", module_event_flag, 8'h01);
      t_wbuf;
      end_of_test;
   end
endmodule
